// ### logic/sra_pkg.sv
// Purpose: Shared types and constants of the dual-channel safety relay control logic.
// Assumes: A 125 MHz system clock; all times below are turned into cycles or milliseconds here.
// Notes:   Delay times are held in milliseconds and counted on a one-millisecond tick.
`default_nettype none
package sra_pkg;

	// ****************************************************************
	// Timing constants
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 8;                         // System clock period in ns.
	localparam int unsigned MS_NS         = 1000000;                   // One millisecond in ns.
	localparam int unsigned TICK_CYC      = MS_NS / CLK_PERIOD_NS;     // Cycles per millisecond tick.
	localparam int unsigned TP_LEN_NS     = 1000;                      // Length of one output test pulse in ns.
	localparam logic [7:0]  TP_CYC        = 8'(TP_LEN_NS / CLK_PERIOD_NS); // Test pulse length in cycles.
	localparam logic [5:0]  TP_PERIOD_MS  = 6'h32;                     // Spacing of test pulses, 50 ms.
	localparam logic [10:0] SUP_GAP_MS    = 11'h014;                   // Supply gap taken as an error, 20 ms.
	localparam logic [10:0] SUP_OFF_MS    = 11'h3e8;                   // Supply off time that rearms, 1 s.
	localparam logic [13:0] INIT_PH_MS    = 14'h0032;                  // Length of each strap probe phase, 50 ms.
	localparam logic [8:0]  BLINK_MS      = 9'h0fa;                    // Half period of indicator flashing, 250 ms.

	// ****************************************************************
	// Error codes shown on the error code output
	// ****************************************************************
	localparam logic [3:0] ERR_NONE     = 4'h0;  // No error.
	localparam logic [3:0] ERR_MODE     = 4'h3;  // Operating mode changed during operation.
	localparam logic [3:0] ERR_SHORT_HI = 4'ha;  // Safety output stuck high during a test pulse.
	localparam logic [3:0] ERR_SUPPLY   = 4'hc;  // Supply interruption longer than the allowed gap.

	// ****************************************************************
	// Types
	// ****************************************************************
	// Control states, one-hot.
	typedef enum logic [4:0] {
		ST_INIT  = 5'h01,
		ST_IDLE  = 5'h02,
		ST_ON    = 5'h04,
		ST_DELAY = 5'h08,
		ST_FAULT = 5'h10
	} sra_state_e;

	// All pin-level inputs; every one of them is asynchronous to the clock.
	typedef struct packed {
		logic supply_ok;       // Supply voltage present and in range.
		logic fb_instant_in;   // Feedback of the instantaneous contactor, also the group strap.
		logic fb_delayed_in;   // Feedback of the delayed contactor, also the step strap.
		logic in_ch_a;         // Input circuit channel A closed.
		logic in_ch_b;         // Input circuit channel B closed.
		logic or_link_in;      // OR link from another unit.
		logic and_link_in;     // AND link from another unit.
		logic start_in;        // Start button pressed.
		logic mode_auto_in;    // Wiring selects automatic start when high.
		logic relay_closed_in; // Relay safety contacts of channel one closed.
		logic rb_instant;      // Read-back level of the instantaneous output pin.
		logic rb_delayed;      // Read-back level of the delayed output pin.
	} sra_pins_s;

	// All outputs of the block.
	typedef struct packed {
		logic       safe_out_instant; // Instantaneous safety output.
		logic       safe_out_delayed; // Delayed safety output.
		logic       pulse_ref_one;    // First pulsed reference for the straps.
		logic       pulse_ref_two;    // Second pulsed reference for the straps.
		logic       power_led;        // Power indicator.
		logic       chan_one_led;     // First channel indicator.
		logic       chan_two_led;     // Second channel indicator.
		logic [3:0] err_code;         // Error code of the last fault.
	} sra_outs_s;

	// ****************************************************************
	// Delay lookup: strap code (group times three plus step) to ms.
	// ****************************************************************
	function automatic logic [13:0] sra_delay_ms(input logic [3:0] code);
		logic [13:0] ms;
		ms = 14'h0000;
		case (code)
			4'h1:    ms = 14'h0096; // 0.15 s.
			4'h2:    ms = 14'h01f4; // 0.5 s.
			4'h3:    ms = 14'h03e8; // 1 s.
			4'h4:    ms = 14'h07d0; // 2 s.
			4'h5:    ms = 14'h0bb8; // 3 s.
			4'h6:    ms = 14'h1388; // 5 s.
			4'h7:    ms = 14'h1b58; // 7 s.
			4'h8:    ms = 14'h2710; // 10 s.
			default: ms = 14'h0000; // 0 s.
		endcase
		return ms;
	endfunction

endpackage
`default_nettype wire

// ### logic/sra_core.sv
// Purpose: Control of a dual-channel safety relay with instantaneous and delayed outputs.
// Assumes: All pins are asynchronous and pass two flip-flops; straps are read during start-up.
// Notes:   Flash-code display of faults is not produced; the error code is given as a plain output.
//
// Summary of operation
// - Feedback straps select group and step of delay.
// - Start presses during the delay are remembered.
// - Remembered start re-enables outputs when delay ends.
// - Automatic mode restarts once input circuit closes.
// - Feedback inputs check instant and delayed contactors.
// - High OR link keeps outputs enabled with the input circuit open.
// - Low AND link forces both outputs low.
// - Start-up probes wiring to detect operating mode.
// - Power indicator flashes in start-up, then steady.
// - Channel one indicator shows instant output, contacts closed.
// - Channel two indicator shows delayed output high.
// - Active outputs get brief low test pulses.
// - A fault cuts the running delay short.
// - Supply gap over 20 ms forces error, outputs low.
// - Lockout ends only after supply off 1 s.
// - Open feedback at start refuses, channels flash alternately.
// - Mode change during operation reports its own error.
`default_nettype none
`timescale 1ns/10ps
module sra_core #(
	parameter int unsigned TICK_CYC = sra_pkg::TICK_CYC // Cycles per millisecond tick.
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire sra_pkg::sra_pins_s pins_in,
	output var  sra_pkg::sra_outs_s outs
);

	// ****************************************************************
	// State record
	// ****************************************************************
	typedef struct packed {
		sra_pkg::sra_state_e st;          // Control state.
		sra_pkg::sra_pins_s  s1;          // First synchroniser stage, read only by the second.
		sra_pkg::sra_pins_s  s2;          // Second synchroniser stage, used by all logic.
		logic                start_prev;  // Previous synchronised start level for edge finding.
		logic [16:0]         tick_cnt;    // Millisecond prescaler.
		logic                ms_tick;     // One-cycle pulse each millisecond.
		logic [13:0]         ms_cnt;      // Millisecond counter for start-up and delay.
		logic [5:0]          tp_ms;       // Milliseconds since the last test pulse.
		logic [7:0]          tp_cyc;      // Cycles into the current test pulse.
		logic                tp_act;      // Test pulse in progress.
		logic [10:0]         sup_ms;      // Milliseconds the supply has been missing.
		logic                lock;        // Supply error lockout.
		logic                armed;       // Supply was off long enough to restart.
		logic                start_latch; // Start press stored during the delay.
		logic                mode_auto;   // Start mode detected at start-up.
		logic                fb_alert;    // Feedback loop was found open on a start.
		logic                blink;       // Flash phase of the indicators.
		logic [8:0]          blink_ms;    // Flash half-period counter.
		logic                en_i;        // Instantaneous output enabled.
		logic                en_d;        // Delayed output enabled.
		logic [1:0]          cap_i;       // Probe result of the instant feedback strap.
		logic [1:0]          cap_d;       // Probe result of the delayed feedback strap.
		logic [3:0]          dly_code;    // Selected delay step, group times three plus step.
		sra_pkg::sra_outs_s  outs;        // Registered outputs.
	} sra_regs_s;

	sra_regs_s r_ff;     // Current state.
	sra_regs_s nxt_r;    // Next state.
	logic      start_edge; // Start button pressed this cycle.
	logic      demand_ok;  // Outputs may be on by the input circuit and links.
	logic      fb_ok;      // Both feedback loops closed.
	logic      mode_chg;   // Wired start mode differs from the detected one.
	logic [13:0] dly_ms;   // Selected delay in milliseconds.

	// Decoded conditions shared by the next-state logic and the checks.
	assign start_edge = r_ff.s2.start_in & ~r_ff.start_prev;
	assign demand_ok  = ((r_ff.s2.in_ch_a & r_ff.s2.in_ch_b) | r_ff.s2.or_link_in) & r_ff.s2.and_link_in;
	assign fb_ok      = r_ff.s2.fb_instant_in & r_ff.s2.fb_delayed_in;
	assign mode_chg   = r_ff.s2.mode_auto_in != r_ff.mode_auto;
	assign dly_ms     = sra_pkg::sra_delay_ms(r_ff.dly_code);
	assign outs       = r_ff.outs;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// Computes the whole next state from the current one and the synchronised pins.
	always_comb begin
		logic tp_fail;
		tp_fail = 1'b0;
		nxt_r = r_ff;
		nxt_r.s1 = pins_in;
		nxt_r.s2 = r_ff.s1;
		nxt_r.start_prev = r_ff.s2.start_in;
		// Millisecond tick.
		if (r_ff.tick_cnt == 17'(TICK_CYC - 1)) begin
			nxt_r.tick_cnt = 17'h00000;
			nxt_r.ms_tick = 1'b1;
		end else begin
			nxt_r.tick_cnt = r_ff.tick_cnt + 17'h00001;
			nxt_r.ms_tick = 1'b0;
		end
		// Flash phase for all flashing indicators.
		if (r_ff.ms_tick) begin
			if (r_ff.blink_ms == sra_pkg::BLINK_MS - 9'h001) begin
				nxt_r.blink_ms = 9'h000;
				nxt_r.blink = ~r_ff.blink;
			end else begin
				nxt_r.blink_ms = r_ff.blink_ms + 9'h001;
			end
		end
		// Supply watch: a long gap locks out, a very long gap rearms.
		if (!r_ff.s2.supply_ok) begin
			if (r_ff.ms_tick && r_ff.sup_ms != sra_pkg::SUP_OFF_MS) begin
				nxt_r.sup_ms = r_ff.sup_ms + 11'h001;
			end
			if (r_ff.sup_ms > sra_pkg::SUP_GAP_MS) begin
				nxt_r.lock = 1'b1;
			end
			if (r_ff.sup_ms >= sra_pkg::SUP_OFF_MS) begin
				nxt_r.armed = 1'b1;
			end
		end else begin
			nxt_r.sup_ms = 11'h000;
		end
		// Test pulses while any output is enabled; the read-back must follow low.
		if (r_ff.en_i | r_ff.en_d) begin
			if (r_ff.tp_act) begin
				if (r_ff.tp_cyc == sra_pkg::TP_CYC - 8'h01) begin
					nxt_r.tp_act = 1'b0;
					nxt_r.tp_cyc = 8'h00;
					tp_fail = (r_ff.en_i & r_ff.s2.rb_instant) | (r_ff.en_d & r_ff.s2.rb_delayed);
				end else begin
					nxt_r.tp_cyc = r_ff.tp_cyc + 8'h01;
				end
			end else if (r_ff.ms_tick) begin
				if (r_ff.tp_ms == sra_pkg::TP_PERIOD_MS - 6'h01) begin
					nxt_r.tp_ms = 6'h00;
					nxt_r.tp_act = 1'b1;
				end else begin
					nxt_r.tp_ms = r_ff.tp_ms + 6'h01;
				end
			end
		end else begin
			nxt_r.tp_act = 1'b0;
			nxt_r.tp_cyc = 8'h00;
			nxt_r.tp_ms = 6'h00;
		end
		// Main control sequence.
		case (r_ff.st)
			sra_pkg::ST_INIT: begin
				// Probe the straps: drive each pulsed reference low in turn and look which input follows.
				nxt_r.en_i = 1'b0;
				nxt_r.en_d = 1'b0;
				if (r_ff.ms_tick) begin
					nxt_r.ms_cnt = r_ff.ms_cnt + 14'h0001;
					if (r_ff.ms_cnt == sra_pkg::INIT_PH_MS - 14'h0001) begin
						nxt_r.cap_i[0] = ~r_ff.s2.fb_instant_in;
						nxt_r.cap_d[0] = ~r_ff.s2.fb_delayed_in;
					end
					if (r_ff.ms_cnt == (sra_pkg::INIT_PH_MS << 1) - 14'h0001) begin
						nxt_r.cap_i[1] = ~r_ff.s2.fb_instant_in;
						nxt_r.cap_d[1] = ~r_ff.s2.fb_delayed_in;
					end
					if (r_ff.ms_cnt == (sra_pkg::INIT_PH_MS << 1)) begin
						if (r_ff.cap_i == 2'h3 || r_ff.cap_d == 2'h3) begin
							// Input low in both phases: loop open, probe again.
							nxt_r.fb_alert = 1'b1;
							nxt_r.ms_cnt = 14'h0000;
						end else begin
							nxt_r.fb_alert = 1'b0;
							nxt_r.dly_code = ({2'h0, r_ff.cap_i} * 4'h3) + {2'h0, r_ff.cap_d};
							nxt_r.mode_auto = r_ff.s2.mode_auto_in;
							nxt_r.st = sra_pkg::ST_IDLE;
						end
					end
				end
			end
			sra_pkg::ST_IDLE: begin
				nxt_r.fb_alert = r_ff.fb_alert & ~fb_ok;
				if (mode_chg) begin
					nxt_r.st = sra_pkg::ST_FAULT;
					nxt_r.outs.err_code = sra_pkg::ERR_MODE;
				end else if (demand_ok && (r_ff.mode_auto || start_edge)) begin
					if (fb_ok) begin
						nxt_r.st = sra_pkg::ST_ON;
						nxt_r.en_i = 1'b1;
						nxt_r.en_d = 1'b1;
						nxt_r.fb_alert = 1'b0;
					end else begin
						nxt_r.fb_alert = 1'b1;
					end
				end
			end
			sra_pkg::ST_ON: begin
				if (tp_fail || mode_chg) begin
					nxt_r.st = sra_pkg::ST_FAULT;
					nxt_r.outs.err_code = tp_fail ? sra_pkg::ERR_SHORT_HI : sra_pkg::ERR_MODE;
				end else if (!demand_ok) begin
					nxt_r.en_i = 1'b0;
					nxt_r.start_latch = 1'b0;
					nxt_r.ms_cnt = 14'h0000;
					if (dly_ms == 14'h0000 || !r_ff.s2.and_link_in) begin
						nxt_r.en_d = 1'b0;
						nxt_r.st = sra_pkg::ST_IDLE;
					end else begin
						nxt_r.st = sra_pkg::ST_DELAY;
					end
				end
			end
			sra_pkg::ST_DELAY: begin
				if (tp_fail || mode_chg) begin
					// A fault ends the delay at once.
					nxt_r.en_d = 1'b0;
					nxt_r.st = sra_pkg::ST_FAULT;
					nxt_r.outs.err_code = tp_fail ? sra_pkg::ERR_SHORT_HI : sra_pkg::ERR_MODE;
				end else if (!r_ff.s2.and_link_in) begin
					nxt_r.en_d = 1'b0;
					nxt_r.st = sra_pkg::ST_IDLE;
				end else if (r_ff.ms_cnt >= dly_ms) begin
					nxt_r.start_latch = 1'b0;
					if ((r_ff.start_latch || start_edge || r_ff.mode_auto) && demand_ok && r_ff.s2.fb_instant_in) begin
						nxt_r.en_i = 1'b1;
						nxt_r.st = sra_pkg::ST_ON;
					end else begin
						nxt_r.en_d = 1'b0;
						nxt_r.st = sra_pkg::ST_IDLE;
					end
				end else begin
					if (start_edge) begin
						nxt_r.start_latch = 1'b1;
					end
					if (r_ff.ms_tick) begin
						nxt_r.ms_cnt = r_ff.ms_cnt + 14'h0001;
					end
				end
			end
			sra_pkg::ST_FAULT: begin
				nxt_r.en_i = 1'b0;
				nxt_r.en_d = 1'b0;
			end
			default: begin
				nxt_r.st = sra_pkg::ST_FAULT;
			end
		endcase
		// Lockout overrides the sequence; only a long supply absence restarts.
		if (r_ff.lock) begin
			nxt_r.st = sra_pkg::ST_FAULT;
			nxt_r.en_i = 1'b0;
			nxt_r.en_d = 1'b0;
			nxt_r.outs.err_code = sra_pkg::ERR_SUPPLY;
		end
		if (r_ff.s2.supply_ok && r_ff.armed) begin
			nxt_r.st = sra_pkg::ST_INIT;
			nxt_r.lock = 1'b0;
			nxt_r.armed = 1'b0;
			nxt_r.ms_cnt = 14'h0000;
			nxt_r.en_i = 1'b0;
			nxt_r.en_d = 1'b0;
			nxt_r.outs.err_code = sra_pkg::ERR_NONE;
		end
		// Pin levels: AND link gates, test pulse blanks.
		nxt_r.outs.safe_out_instant = nxt_r.en_i & r_ff.s2.and_link_in & ~nxt_r.tp_act;
		nxt_r.outs.safe_out_delayed = nxt_r.en_d & r_ff.s2.and_link_in & ~nxt_r.tp_act;
		nxt_r.outs.pulse_ref_one = !(nxt_r.st == sra_pkg::ST_INIT && nxt_r.ms_cnt < sra_pkg::INIT_PH_MS);
		nxt_r.outs.pulse_ref_two = !(nxt_r.st == sra_pkg::ST_INIT && nxt_r.ms_cnt >= sra_pkg::INIT_PH_MS);
		nxt_r.outs.power_led = (nxt_r.st == sra_pkg::ST_INIT) ? nxt_r.blink : 1'b1;
		if (nxt_r.st == sra_pkg::ST_FAULT) begin
			nxt_r.outs.chan_one_led = nxt_r.blink;
			nxt_r.outs.chan_two_led = nxt_r.blink;
		end else if (nxt_r.fb_alert) begin
			nxt_r.outs.chan_one_led = nxt_r.blink;
			nxt_r.outs.chan_two_led = ~nxt_r.blink;
		end else begin
			nxt_r.outs.chan_one_led = nxt_r.en_i & r_ff.s2.and_link_in & r_ff.s2.relay_closed_in;
			nxt_r.outs.chan_two_led = nxt_r.en_d & r_ff.s2.and_link_in;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Synchronous reset puts every field to a constant and starts probing.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r_ff <= '0;
			r_ff.st <= sra_pkg::ST_INIT;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	and_link_gate_a: assert property (!r_ff.s2.and_link_in |=> !outs.safe_out_instant && !outs.safe_out_delayed)
		else $error("Output high with AND link low.");
	lock_outputs_low_a: assert property (r_ff.lock |=> ##1 !outs.safe_out_instant && !outs.safe_out_delayed)
		else $error("Output high during supply lockout.");
	lock_holds_a: assert property (r_ff.lock && !r_ff.armed |=> r_ff.lock)
		else $error("Lockout cleared without a long supply removal.");
	power_steady_a: assert property (r_ff.st == sra_pkg::ST_IDLE |-> outs.power_led)
		else $error("Power indicator not steady when ready.");
	init_probe_a: assert property (r_ff.st == sra_pkg::ST_INIT |-> !(outs.safe_out_instant || outs.safe_out_delayed))
		else $error("Output driven during start-up.");
	latch_kept_a: assert property (r_ff.start_latch && r_ff.st == sra_pkg::ST_DELAY && r_ff.ms_cnt < dly_ms
		&& r_ff.s2.and_link_in && !mode_chg && !r_ff.tp_act && !r_ff.lock |=> r_ff.start_latch)
		else $error("Stored start press lost during the delay.");
	// A pulse is cut short legally when both enables drop, so the length is only judged while one stays on.
	pulse_blanks_a: assert property ($rose(r_ff.tp_act) ##0 (r_ff.en_i || r_ff.en_d)[*7]
		|=> r_ff.tp_act && !outs.safe_out_instant && !outs.safe_out_delayed)
		else $error("Test pulse too short or output not blanked.");
	mode_fault_a: assert property (r_ff.st == sra_pkg::ST_ON && mode_chg && !r_ff.tp_act && !r_ff.lock && !r_ff.armed
		|=> r_ff.st == sra_pkg::ST_FAULT && outs.err_code == sra_pkg::ERR_MODE)
		else $error("Mode change not reported.");
	feedback_refuse_a: assert property (r_ff.st == sra_pkg::ST_IDLE && !fb_ok |=> r_ff.st != sra_pkg::ST_ON)
		else $error("Outputs enabled with feedback open.");
	chan_two_shows_a: assert property (r_ff.st == sra_pkg::ST_ON && !r_ff.fb_alert && $stable(r_ff.s2.and_link_in)
		&& $past(r_ff.st) == sra_pkg::ST_ON |-> outs.chan_two_led == r_ff.s2.and_link_in)
		else $error("Channel two indicator wrong.");

	reach_on_c: cover property (r_ff.st == sra_pkg::ST_IDLE ##1 r_ff.st == sra_pkg::ST_ON);
	delay_restart_c: cover property (r_ff.st == sra_pkg::ST_DELAY && r_ff.start_latch ##1 r_ff.st == sra_pkg::ST_ON);
	fault_entry_c: cover property (r_ff.st != sra_pkg::ST_FAULT ##1 r_ff.st == sra_pkg::ST_FAULT);
	fb_alert_c: cover property ($rose(r_ff.fb_alert));

endmodule
`default_nettype wire

// ### sim/sra_far_model.sv
// Purpose: Far side of the relay: feedback straps and output read-back.
// Assumes: A strap ties a feedback pin to supply, to a pulsed reference, or to nothing.
// Notes:   An open strap reads low; a commanded short holds both read-backs high.
`default_nettype none
`timescale 1ns/10ps
module sra_far_model (
	input  wire logic       ref_one,  // First pulsed reference.
	input  wire logic       ref_two,  // Second pulsed reference.
	input  wire logic       out_inst, // Instantaneous output pin.
	input  wire logic       out_dly,  // Delayed output pin.
	input  wire logic [1:0] src_inst, // Instant strap: 0 supply, 1 ref one, 2 ref two, 3 open.
	input  wire logic [1:0] src_dly,  // Delayed strap, same coding.
	input  wire logic       short_hi, // Short of both outputs to supply.
	output logic            fb_inst,  // Instant feedback pin.
	output logic            fb_dly,   // Delayed feedback pin.
	output logic            rb_inst,  // Instant read-back.
	output logic            rb_dly    // Delayed read-back.
);
	// Feedback is a plain strap and never passes through the start circuit.
	always_comb begin
		fb_inst = (src_inst == 2'h0) | ((src_inst == 2'h1) & ref_one) | ((src_inst == 2'h2) & ref_two);
		fb_dly  = (src_dly == 2'h0) | ((src_dly == 2'h1) & ref_one) | ((src_dly == 2'h2) & ref_two);
	end
	// Read-back follows the pins, so test pulses show unless a short is commanded.
	assign rb_inst = out_inst | short_hi;
	assign rb_dly  = out_dly | short_hi;
endmodule
`default_nettype wire

// ### sim/safety_relay_output_control_test.sv
// Purpose: Scenario bench of the safety relay control.
// Assumes: TICK_CYC is 10, so one millisecond tick is ten cycles.
// Notes:   Outputs carry test pulses, so levels are judged over windows of cycles.
`default_nettype none
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module safety_relay_output_control_test;
	logic               clk_sys  = 1'b0; // System clock.
	logic               rst_n    = 1'b0; // Synchronous reset.
	sra_pkg::sra_pins_s drv;             // Pins driven by the bench.
	sra_pkg::sra_pins_s pins_in;         // Pins seen by the block.
	sra_pkg::sra_outs_s outs;            // Block outputs.
	logic [1:0]         src_i    = 2'h0; // Instant strap.
	logic [1:0]         src_d    = 2'h1; // Delayed strap.
	logic               short_hi = 1'b0; // Commanded short.
	logic               fb_i;            // Feedback and read-back from the model.
	logic               fb_d;
	logic               rb_i;
	logic               rb_d;
	logic [5:0]         w;               // Window flags.
	int                 n_errors = 0;    // Mismatches.
	int                 checked  = 0;    // Comparisons.
	always #4 clk_sys = ~clk_sys;
	// Merge the far-side pins into the bench pins.
	always_comb begin
		pins_in                 = drv;
		pins_in.fb_instant_in   = fb_i;
		pins_in.fb_delayed_in   = fb_d;
		pins_in.rb_instant      = rb_i;
		pins_in.rb_delayed      = rb_d;
	end
	sra_core #(.TICK_CYC(10)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pins_in(pins_in), .outs(outs));
	sra_far_model i_far (.ref_one(outs.pulse_ref_one), .ref_two(outs.pulse_ref_two),
		.out_inst(outs.safe_out_instant), .out_dly(outs.safe_out_delayed), .src_inst(src_i),
		.src_dly(src_d), .short_hi(short_hi), .fb_inst(fb_i), .fb_dly(fb_d), .rb_inst(rb_i), .rb_dly(rb_d));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Flags over n cycles: instant high, delayed high, instant low, led one, led two, leds unequal.
	task automatic watch(input int n);
		w = 6'h00;
		repeat (n) begin
			@(negedge clk_sys);
			w |= {outs.safe_out_instant, outs.safe_out_delayed, ~outs.safe_out_instant,
				outs.chan_one_led, outs.chan_two_led, outs.chan_one_led ^ outs.chan_two_led};
		end
		@(posedge clk_sys);
	endtask
	// The button is released except for this deliberate press.
	task automatic press;
		@(posedge clk_sys);
		drv.start_in <= 1'b1;
		cyc(4);
		drv.start_in <= 1'b0;
	endtask
	// Supply off for over a second, new wiring, then a full start-up.
	task automatic recover(input logic auto_m, input logic [1:0] sd);
		@(posedge clk_sys);
		drv.supply_ok <= 1'b0;
		cyc(10100);
		drv.mode_auto_in <= auto_m;
		src_d <= sd;
		drv.supply_ok <= 1'b1;
		cyc(1300);
		@(negedge clk_sys);
		`CHK("err_code", sra_pkg::ERR_NONE, outs.err_code)
		`CHK("power_led", 1'b1, outs.power_led)
	endtask
	task automatic t_init;
		cyc(4);
		@(negedge clk_sys);
		`CHK("outs in reset", 11'h000, outs)
		@(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(300);
		@(negedge clk_sys);
		`CHK("refs phase one", 2'h1, {outs.pulse_ref_one, outs.pulse_ref_two})
		`CHK("power in init", 1'b0, outs.power_led)
		cyc(500);
		@(negedge clk_sys);
		`CHK("refs phase two", 2'h2, {outs.pulse_ref_one, outs.pulse_ref_two})
		watch(500);
		`CHK("no output before start", 2'h0, w[5:4])
		`CHK("power steady", 1'b1, outs.power_led)
		$display("test init done");
	endtask
	task automatic t_fb_open;
		src_i <= 2'h3;
		press();
		watch(3000);
		`CHK("open loop outputs", 2'h0, w[5:4])
		`CHK("leds alternate", 1'b1, w[0])
		src_i <= 2'h0;
		drv.relay_closed_in <= 1'b0;
		cyc(10);
		$display("test open feedback done");
	endtask
	task automatic t_start;
		press();
		watch(200);
		`CHK("started outputs", 2'h3, w[5:4])
		`CHK("led two", 1'b1, w[1])
		`CHK("led one contacts open", 1'b0, w[2])
		drv.relay_closed_in <= 1'b1;
		watch(200);
		`CHK("led one contacts closed", 1'b1, w[2])
		drv.and_link_in <= 1'b0;
		cyc(4);
		watch(200);
		`CHK("and link low", 2'h0, w[5:4])
		drv.and_link_in <= 1'b1;
		press();
		watch(200);
		`CHK("and link high", 2'h3, w[5:4])
		$display("test start and link done");
	endtask
	task automatic t_or_delay;
		drv.or_link_in <= 1'b1;
		drv.in_ch_a <= 1'b0;
		watch(200);
		`CHK("or link holds", 1'b1, w[5])
		drv.or_link_in <= 1'b0;
		cyc(4);
		watch(200);
		`CHK("delay running", 2'h1, w[5:4])
		drv.in_ch_a <= 1'b1;
		press();
		watch(700);
		`CHK("latched start waits", 1'b0, w[5])
		watch(800);
		`CHK("on after delay", 1'b1, w[5])
		$display("test or link and delay done");
	endtask
	task automatic t_pulse;
		watch(600);
		`CHK("test pulse low", 1'b1, w[3])
		// Open the input so the delay runs, then short: the fault must end the delay early.
		drv.in_ch_a <= 1'b0;
		cyc(4);
		short_hi <= 1'b1;
		cyc(700);
		@(negedge clk_sys);
		`CHK("stuck high code", sra_pkg::ERR_SHORT_HI, outs.err_code)
		watch(200);
		`CHK("stuck high off", 2'h0, w[5:4])
		short_hi <= 1'b0;
		drv.in_ch_a <= 1'b0;
		$display("test pulse done");
	endtask
	task automatic t_auto;
		recover(1'b1, 2'h2);
		watch(200);
		`CHK("auto open input", 2'h0, w[5:4])
		drv.in_ch_a <= 1'b1;
		watch(200);
		`CHK("auto restart", 2'h3, w[5:4])
		drv.in_ch_a <= 1'b0;
		cyc(4300);
		watch(300);
		`CHK("long delay held", 1'b1, w[4])
		cyc(500);
		watch(300);
		`CHK("long delay over", 1'b0, w[4])
		drv.in_ch_a <= 1'b1;
		watch(200);
		drv.supply_ok <= 1'b0;
		cyc(300);
		drv.supply_ok <= 1'b1;
		cyc(20);
		@(negedge clk_sys);
		`CHK("supply gap code", sra_pkg::ERR_SUPPLY, outs.err_code)
		watch(300);
		`CHK("locked out", 2'h0, w[5:4])
		`CHK("fault leds together", 1'b0, w[0])
		$display("test auto and supply done");
	endtask
	task automatic t_mode;
		recover(1'b0, 2'h1);
		press();
		watch(200);
		`CHK("monitored on", 2'h3, w[5:4])
		drv.mode_auto_in <= 1'b1;
		cyc(20);
		@(negedge clk_sys);
		`CHK("mode change code", sra_pkg::ERR_MODE, outs.err_code)
		watch(200);
		`CHK("mode change off", 2'h0, w[5:4])
		$display("test mode change done");
	endtask
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watchdog well beyond the roughly forty thousand cycles the tests need.
	initial begin
		cyc(80000);
		n_errors++;
		$display("[FAIL] watchdog exp done got timeout");
		give_verdict();
	end
	initial begin
		drv = '{supply_ok: 1'b1, in_ch_a: 1'b1, in_ch_b: 1'b1, and_link_in: 1'b1, relay_closed_in: 1'b1, default: 1'b0};
		t_init();
		t_fb_open();
		t_start();
		t_or_delay();
		t_pulse();
		t_auto();
		t_mode();
		give_verdict();
	end
endmodule
`default_nettype wire
